// >>> src/scdiv_params.svh
// Register offsets, field positions and reset values of the clock divider
`ifndef SCDIV_PARAMS_SVH
`define SCDIV_PARAMS_SVH
`define SCDIV_SPAN_OFFSET 9'h018
`define SCDIV_SYNC_OFFSET 9'h100
`define SCDIV_DIV_OFFSET 9'h00B
`define SCDIV_STAB_OFFSET 9'h009
`define SCDIV_SPAN_RESET 8'hE0
`define SCDIV_SYNC_RESET 8'h00
`define SCDIV_DIV_RESET 8'h00
`define SCDIV_STAB_RESET 8'h01
`define SCDIV_SYNC_EN_BIT 0
`define SCDIV_SYNC_ONCE_BIT 1
`define SCDIV_SYNC_EVERY_BIT 2
`define SCDIV_SPAN_1V00 8'hC0
`define SCDIV_SPAN_1V14 8'hC8
`define SCDIV_SPAN_1V33 8'hD0
`define SCDIV_SPAN_1V60 8'hD8
`define SCDIV_SPAN_2V00 8'hE0
`endif

// >>> src/scdiv_pkg.sv
// Types of the sample clock divider
package scdiv_pkg;
    typedef logic [2:0] scdiv_span_t;
    typedef enum logic [1:0] {
        SCDIV_SYNC_OFF = 2'b00,
        SCDIV_SYNC_ARMED = 2'b01,
        SCDIV_SYNC_DONE = 2'b11
    } scdiv_sync_e;
    localparam scdiv_span_t SCDIV_SPAN_CODE_1V00 = 3'h0;
    localparam scdiv_span_t SCDIV_SPAN_CODE_1V14 = 3'h1;
    localparam scdiv_span_t SCDIV_SPAN_CODE_1V33 = 3'h2;
    localparam scdiv_span_t SCDIV_SPAN_CODE_1V60 = 3'h3;
    localparam scdiv_span_t SCDIV_SPAN_CODE_2V00 = 3'h4;
endpackage

// >>> src/scdiv_counter.sv
// Divide-by-N counter with realignment
`timescale 1ns/100ps
`include "scdiv_params.svh"
module scdiv_counter
    import scdiv_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] div_sel,
    input wire logic realign,
    output logic clk_div,
    output logic sample_strobe
);
    logic [2:0] count;
    logic [2:0] next_count;
    logic [3:0] half;

    assign half = ({1'b0, div_sel} + 4'h1) >> 1;

    always_comb begin
        next_count = (count == div_sel) ? 3'h0 : count + 3'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst || realign) begin
            count <= 3'h0;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || realign) begin
            clk_div <= 1'b1;
        end else if (div_sel == 3'h0) begin
            clk_div <= ~clk_div;
        end else begin
            // Rise only at count zero, even across a ratio change
            clk_div <= (next_count == 3'h0)
                || (clk_div && ({1'b0, next_count} < half));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || realign) begin
            sample_strobe <= 1'b1;
        end else begin
            sample_strobe <= (next_count == 3'h0);
        end
    end
endmodule

// >>> src/scdiv_top.sv
// Sample clock divider, sync control and span decoder
`timescale 1ns/100ps
`include "scdiv_params.svh"
// Contract
// - Divide input clock by any integer ratio from one to eight; at ratio one clk_div toggles, dividing by two.
// - External sync input realigns the divider across devices.
// - Bit one picks first-pulse-after-write sync when set, every-pulse sync when clear.
// - Each valid sync returns the divider counter to initial state.
// - Span register codes C0..E0 select 1.0 to 2.0 V p-p span.
// - A new sample is taken on each internal clock rising edge.
module scdiv_top
    import scdiv_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sync_in,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic clk_div,
    output logic sample_strobe,
    output logic duty_cycle_stabilizer,
    output logic [2:0] span_code,
    output logic span_valid,
    output logic sync_seen
);
    logic [7:0] span_reg;
    logic [7:0] sync_reg;
    logic [7:0] div_reg;
    logic [7:0] stab_reg;
    logic sync_q;
    logic sync_rise;
    logic realign;
    scdiv_sync_e sync_state;

    function automatic logic sel(input logic [8:0] a, input logic [8:0] o);
        sel = (a == o);
    endfunction

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            span_reg <= `SCDIV_SPAN_RESET;
            div_reg <= `SCDIV_DIV_RESET;
            stab_reg <= `SCDIV_STAB_RESET;
        end else if (reg_wr) begin
            if (sel(reg_addr, `SCDIV_SPAN_OFFSET)) begin
                span_reg <= reg_wdata;
            end
            if (sel(reg_addr, `SCDIV_DIV_OFFSET)) begin
                div_reg <= {5'h00, reg_wdata[2:0]};
            end
            if (sel(reg_addr, `SCDIV_STAB_OFFSET)) begin
                stab_reg <= {7'h00, reg_wdata[0]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_reg <= `SCDIV_SYNC_RESET;
        end else if (reg_wr && sel(reg_addr, `SCDIV_SYNC_OFFSET)) begin
            sync_reg <= {5'h00, reg_wdata[2:0]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (sel(reg_addr, `SCDIV_SPAN_OFFSET)) begin
                reg_rdata <= span_reg;
            end else if (sel(reg_addr, `SCDIV_SYNC_OFFSET)) begin
                reg_rdata <= {sync_reg[7:4], sync_seen, sync_reg[2:0]};
            end else if (sel(reg_addr, `SCDIV_DIV_OFFSET)) begin
                reg_rdata <= div_reg;
            end else if (sel(reg_addr, `SCDIV_STAB_OFFSET)) begin
                reg_rdata <= stab_reg;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= sync_in;
        end
    end
    assign sync_rise = sync_in && !sync_q;

    // Write rearms one-shot and wins over a pulse in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_state <= SCDIV_SYNC_OFF;
        end else if (reg_wr && sel(reg_addr, `SCDIV_SYNC_OFFSET)) begin
            sync_state <= SCDIV_SYNC_ARMED;
        end else begin
            unique case (sync_state)
                SCDIV_SYNC_OFF: sync_state <= SCDIV_SYNC_OFF;
                SCDIV_SYNC_ARMED: begin
                    if (sync_rise && sync_reg[`SCDIV_SYNC_EN_BIT]) begin
                        sync_state <= SCDIV_SYNC_DONE;
                    end
                end
                SCDIV_SYNC_DONE: sync_state <= SCDIV_SYNC_DONE;
                default: sync_state <= SCDIV_SYNC_OFF;
            endcase
        end
    end

    // every pulse or first after write
    always_comb begin
        realign = 1'b0;
        if (sync_rise && sync_reg[`SCDIV_SYNC_EN_BIT]) begin
            if (!sync_reg[`SCDIV_SYNC_ONCE_BIT]) begin
                realign = 1'b1;
            end else if (sync_state == SCDIV_SYNC_ARMED) begin
                realign = 1'b1;
            end
        end
    end

    // Sticky flag; a realign beats the clearing write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_seen <= 1'b0;
        end else if (realign) begin
            sync_seen <= 1'b1;
        end else if (reg_wr && sel(reg_addr, `SCDIV_SYNC_OFFSET)) begin
            sync_seen <= 1'b0;
        end
    end

    scdiv_counter scdiv_counter_inst (
        .ref_clk(ref_clk),
        .rst(rst),
        .div_sel(div_reg[2:0]),
        .realign(realign),
        .clk_div(clk_div),
        .sample_strobe(sample_strobe)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            duty_cycle_stabilizer <= 1'b1;
        end else begin
            duty_cycle_stabilizer <= stab_reg[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            span_code <= SCDIV_SPAN_CODE_2V00;
            span_valid <= 1'b1;
        end else begin
            span_valid <= 1'b1;
            unique case (span_reg)
                `SCDIV_SPAN_1V00: span_code <= SCDIV_SPAN_CODE_1V00;
                `SCDIV_SPAN_1V14: span_code <= SCDIV_SPAN_CODE_1V14;
                `SCDIV_SPAN_1V33: span_code <= SCDIV_SPAN_CODE_1V33;
                `SCDIV_SPAN_1V60: span_code <= SCDIV_SPAN_CODE_1V60;
                `SCDIV_SPAN_2V00: span_code <= SCDIV_SPAN_CODE_2V00;
                // Unlisted codes keep full span, flagged invalid
                default: begin
                    span_code <= SCDIV_SPAN_CODE_2V00;
                    span_valid <= 1'b0;
                end
            endcase
        end
    end
endmodule

// >>> verif/scdiv_sync_src.sv
// External sync pulse source facing the divider
`timescale 1ns/100ps
module scdiv_sync_src (
    input wire logic ref_clk,
    output logic sync_in
);
    initial sync_in = 1'h0;
    task automatic pulse(input int len);
        @(negedge ref_clk);
        sync_in = 1'h1;
        repeat (len) @(negedge ref_clk);
        sync_in = 1'h0;
    endtask
endmodule

// >>> verif/scdiv_top_assertions.sv
// Port checker of the sample clock divider
`timescale 1ns/100ps
`include "scdiv_params.svh"
module scdiv_top_checker
    import scdiv_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sync_in,
    input wire logic reg_wr,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic clk_div,
    input wire logic sample_strobe,
    input wire logic duty_cycle_stabilizer,
    input wire logic [2:0] span_code,
    input wire logic span_valid,
    input wire logic sync_seen
);
    logic [2:0] ratio;
    logic sy_wr;
    assign sy_wr = reg_wr && reg_addr == `SCDIV_SYNC_OFFSET;
    // Shadow of N-1, as the divider register is not visible
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ratio <= 3'h0;
        end else if (reg_wr && reg_addr == `SCDIV_DIV_OFFSET) begin
            ratio <= reg_wdata[2:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_span_code: assert property (
        reg_wr && reg_addr == `SCDIV_SPAN_OFFSET && reg_wdata == 8'hD0
        ##1 !reg_wr |=> span_code == SCDIV_SPAN_CODE_1V33 && span_valid)
        else $error("span code");
    a_strobe_rise: assert property (
        $rose(clk_div) |-> sample_strobe) else $error("strobe");
    a_realign_phase: assert property (
        $rose(sync_seen) |-> sample_strobe && clk_div) else $error("realign");
    a_seen_clear: assert property (
        sy_wr && !sync_in |=> !sync_seen) else $error("seen clear");
    a_seen_hold: assert property (
        sync_seen && !sy_wr |=> sync_seen) else $error("seen hold");
    a_div_four: assert property (
        disable iff (rst || reg_wr || sync_in)
        sample_strobe && ratio == 3'h3 |-> clk_div ##1 clk_div
        ##1 !clk_div ##1 !clk_div ##1 sample_strobe) else $error("div four");
    a_div_eight: assert property (
        disable iff (rst || reg_wr || sync_in)
        sample_strobe && ratio == 3'h7 |=> !sample_strobe [*7]
        ##1 sample_strobe) else $error("div eight");
    a_stab_copy: assert property (
        reg_wr && reg_addr == `SCDIV_STAB_OFFSET ##1 !reg_wr
        |=> duty_cycle_stabilizer == $past(reg_wdata[0], 2))
        else $error("stabilizer");
endmodule
bind scdiv_top scdiv_top_checker scdiv_top_checker_inst (.ref_clk, .rst,
    .sync_in, .reg_wr, .reg_addr, .reg_wdata, .clk_div, .sample_strobe,
    .duty_cycle_stabilizer, .span_code, .span_valid, .sync_seen);

// >>> verif/sample_clock_divider_sync_tb.sv
// Testbench of the sample clock divider
`timescale 1ns/100ps
`include "scdiv_params.svh"
module sample_clock_divider_sync_tb import scdiv_pkg::*;;
    logic ref_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic sync_in, clk_div, sample_strobe, span_valid, sync_seen, stab;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [2:0] span_code;
    int mismatches = 0, total_checks = 0, n;
    always #4 ref_clk = ~ref_clk;
    scdiv_sync_src scdiv_sync_src_inst (.ref_clk, .sync_in);
    scdiv_top scdiv_top_inst (.ref_clk, .rst, .sync_in, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .clk_div, .sample_strobe,
        .duty_cycle_stabilizer(stab), .span_code, .span_valid, .sync_seen);
    task automatic chk(input string s, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'h0;
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        reg_rd = 1'h1;
        reg_addr = a;
        @(negedge ref_clk);
        reg_rd = 1'h0;
        chk("reg_rdata", e, reg_rdata);
    endtask
    // Bounded wait for the next strobe; n is the span in cycles
    task automatic gap();
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (sample_strobe !== 1'h1 && n < 20);
    endtask
    task automatic pulse_chk(input logic e);
        scdiv_sync_src_inst.pulse(1);
        chk("sample_strobe", 8'(e), 8'(sample_strobe));
        // Realign restarts the high phase of the divided clock
        if (e) begin
            chk("clk_div", 8'h01, 8'(clk_div));
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'h0;
        rd(`SCDIV_SPAN_OFFSET, `SCDIV_SPAN_RESET);
        rd(`SCDIV_SYNC_OFFSET, `SCDIV_SYNC_RESET);
        rd(`SCDIV_DIV_OFFSET, `SCDIV_DIV_RESET);
        rd(`SCDIV_STAB_OFFSET, `SCDIV_STAB_RESET);
        rd(9'h001, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(`SCDIV_SPAN_OFFSET, 8'hC0 + 8'(i * 8));
            @(negedge ref_clk);
            chk("span_code", 8'(i), 8'(span_code));
            chk("span_valid", 8'h01, 8'(span_valid));
        end
        // Unlisted code falls back to full span, flagged invalid
        wr(`SCDIV_SPAN_OFFSET, 8'hC4);
        @(negedge ref_clk);
        chk("span_code", 8'(SCDIV_SPAN_CODE_2V00), 8'(span_code));
        chk("span_valid", 8'h00, 8'(span_valid));
        $display("test span done");
        for (int r = 0; r < 8; r++) begin
            wr(`SCDIV_DIV_OFFSET, 8'(r));
            wr(`SCDIV_STAB_OFFSET, 8'(r != 0 && r != 1 && r != 3));
            @(negedge ref_clk);
            chk("stab", 8'(r != 0 && r != 1 && r != 3), 8'(stab));
            gap();
            gap();
            chk("strobe_gap", 8'(r + 1), 8'(n));
        end
        $display("test divider done");
        wr(`SCDIV_SYNC_OFFSET, 8'h05);
        pulse_chk(1'h1);
        pulse_chk(1'h1);
        wr(`SCDIV_SYNC_OFFSET, 8'h03);
        chk("sync_seen", 8'h00, 8'(sync_seen));
        pulse_chk(1'h1);
        rd(`SCDIV_SYNC_OFFSET, 8'h0B);
        pulse_chk(1'h0);
        wr(`SCDIV_SYNC_OFFSET, 8'h00);
        chk("sync_seen", 8'h00, 8'(sync_seen));
        @(negedge ref_clk);
        pulse_chk(1'h0);
        $display("test sync done");
        stop_test();
    end
endmodule
